// ==== hw/logic_string_op_decoder.v ====
// byte-serial decoder for test/invert/accumulator-and, string ops and double left shift
`timescale 1ns/1ps
`default_nettype none
`include "decoder_defs.vh"

module logic_string_op_decoder #(
	parameter COST_W = 40
) (
	input  wire              CLK_SYS,
	input  wire              RST_B,
	input  wire              QUEUE_VALID,
	input  wire [7:0]        QUEUE_BYTE,
	output wire              QUEUE_READY,
	input  wire [1:0]        MODE,
	input  wire              PRIV_OK,
	input  wire              OPERAND_32,
	input  wire              COUNT_WIDE,
	input  wire [31:0]       COUNT_VALUE,
	input  wire              SEQ_ACCEPT,
	output wire              DEC_VALID,
	output wire [3:0]        DEC_OP,
	output wire              DEC_WIDE,
	output wire              DEC_WORD32,
	output wire              DEC_MEM,
	output wire [31:0]       DEC_IMM,
	output wire [31:0]       DEC_ITER,
	output wire [COST_W-1:0] DEC_CLOCKS,
	output wire              DEC_UNSUPPORTED
);

	////////////////////////////////////////////////////////////////////////
	// state and registers

	localparam [2:0] ST_OPCODE = 3'h0;
	localparam [2:0] ST_ESCAPE = 3'h1;
	localparam [2:0] ST_MODRM  = 3'h2;
	localparam [2:0] ST_IMM    = 3'h3;
	localparam [2:0] ST_CALC   = 3'h4;
	localparam [2:0] ST_HOLD   = 3'h5;

	reg  [2:0]        state_reg;
	reg  [2:0]        state_next;
	reg               rep_reg;
	reg               rep_next;
	reg  [3:0]        op_reg;
	reg  [3:0]        op_next;
	reg               wide_reg;
	reg               wide_next;
	reg               word32_reg;
	reg               word32_next;
	reg               mem_reg;
	reg               mem_next;
	reg  [2:0]        imm_left_reg;
	reg  [2:0]        imm_left_next;
	reg  [1:0]        imm_idx_reg;
	reg  [1:0]        imm_idx_next;
	reg  [31:0]       iter_reg;
	reg  [31:0]       iter_next;
	reg  [COST_W-1:0] clocks_reg;
	reg               valid_reg;
	reg               bad_reg;
	reg               bad_next;
	reg               ready_reg;
	wire [COST_W-1:0] cost;
	wire              take;
	wire [6:0]        body;
	wire [1:0]        mod_field;
	wire [2:0]        sub_field;
	wire [2:0]        imm_len;

	assign take      = QUEUE_VALID & ready_reg;
	assign body      = QUEUE_BYTE[7:1];
	assign mod_field = QUEUE_BYTE[`MODRM_MOD_MSB:`MODRM_MOD_LSB];
	assign sub_field = QUEUE_BYTE[`MODRM_REG_MSB:`MODRM_REG_LSB];
	// byte, word or doubleword immediate
	// short forms go straight to the immediate, so size it from the opcode byte itself
	assign imm_len   = (state_reg == ST_OPCODE) ?
		(!QUEUE_BYTE[0] ? `IMM_LEN_BYTE : (OPERAND_32 ? `IMM_LEN_DWORD : `IMM_LEN_WORD)) :
		(!wide_reg ? `IMM_LEN_BYTE : (word32_reg ? `IMM_LEN_DWORD : `IMM_LEN_WORD));

	////////////////////////////////////////////////////////////////////////
	// next-state decode

	always @* begin
		state_next    = state_reg;
		rep_next      = rep_reg;
		op_next       = op_reg;
		wide_next     = wide_reg;
		word32_next   = word32_reg;
		mem_next      = mem_reg;
		imm_left_next = imm_left_reg;
		imm_idx_next  = imm_idx_reg;
		iter_next     = iter_reg;
		bad_next      = 1'b0;
		case (state_reg)
			ST_OPCODE: begin
				if (take) begin
					wide_next    = QUEUE_BYTE[0];
					word32_next  = QUEUE_BYTE[0] & OPERAND_32;
					mem_next     = 1'b0;
					imm_idx_next = 2'h0;
					iter_next    = 32'h00000000;
					state_next   = ST_CALC;
					if (QUEUE_BYTE == `PREFIX_ITERATE) begin
						rep_next   = 1'b1;
						state_next = ST_OPCODE;
					end else if (QUEUE_BYTE == `ESCAPE_BYTE && !rep_reg) begin
						state_next = ST_ESCAPE;
					end else if (rep_reg) begin
						if (body == `OPC_CMP_STR) begin
							op_next = `OP_CMP_REP;
							iter_next = COUNT_WIDE ? COUNT_VALUE : (COUNT_VALUE & `SHORT_COUNT_MSK);
						end else begin
							bad_next   = 1'b1;
							rep_next   = 1'b0;
							state_next = ST_OPCODE;
						end
					end else begin
						case (body)
							`OPC_GROUP3: begin
								// a shift left over from before must not steer the operand byte
								op_next    = `OP_NONE;
								state_next = ST_MODRM;
							end
							`OPC_TEST_ACC: begin
								op_next    = `OP_TEST_ACC;
								state_next = ST_IMM;
							end
							`OPC_AND_ACC: begin
								op_next    = `OP_AND_ACC;
								state_next = ST_IMM;
							end
							`OPC_CMP_STR:   op_next = `OP_CMP_STR;
							`OPC_IN_STR:    op_next = `OP_IN_STR;
							`OPC_OUT_STR:   op_next = `OP_OUT_STR;
							`OPC_LOAD_STR:  op_next = `OP_LOAD_STR;
							`OPC_MOVE_STR:  op_next = `OP_MOVE_STR;
							`OPC_SCAN_STR:  op_next = `OP_SCAN_STR;
							`OPC_STORE_STR: op_next = `OP_STORE_STR;
							default: begin
								bad_next   = 1'b1;
								state_next = ST_OPCODE;
							end
						endcase
					end
				end
			end
			ST_ESCAPE: begin
				if (take) begin
					if (QUEUE_BYTE == `OPC2_DBL_SHL) begin
						op_next    = `OP_DBL_SHL;
						state_next = ST_MODRM;
					end else begin
						bad_next   = 1'b1;
						state_next = ST_OPCODE;
					end
				end
			end
			ST_MODRM: begin
				if (take) begin
					mem_next   = (mod_field != `MOD_REGISTER);
					state_next = ST_CALC;
					if (op_reg == `OP_DBL_SHL) begin
						// shift count is always one byte
						wide_next   = 1'b0;
						word32_next = 1'b0;
						state_next  = ST_IMM;
					end else if (sub_field == `SUB_TEST) begin
						op_next    = `OP_TEST_IMM;
						state_next = ST_IMM;
					end else if (sub_field == `SUB_INVERT) begin
						op_next = `OP_INVERT;
					end else begin
						bad_next   = 1'b1;
						state_next = ST_OPCODE;
					end
				end
			end
			ST_IMM: begin
				if (take) begin
					imm_idx_next = imm_idx_reg + 2'h1;
					if (imm_left_reg == `IMM_LEN_BYTE)
						state_next = ST_CALC;
				end
			end
			ST_CALC: begin
				state_next = ST_HOLD;
			end
			ST_HOLD: begin
				if (SEQ_ACCEPT) begin
					rep_next   = 1'b0;
					state_next = ST_OPCODE;
				end
			end
			default: begin
				state_next = ST_OPCODE;
			end
		endcase
		// immediate length known once the size is fixed
		if (state_reg != ST_IMM)
			imm_left_next = imm_len;
		else if (take)
			imm_left_next = imm_left_reg - 3'h1;
		// size of shift count overrides the operand size
		if (op_next == `OP_DBL_SHL && state_reg != ST_IMM)
			imm_left_next = `IMM_LEN_BYTE;
	end

	////////////////////////////////////////////////////////////////////////
	// cost of the decoded operation

	clock_cost_calc #(
		.COST_W  (COST_W)
	) u_cost (
		.op      (op_reg),
		.mem     (mem_reg),
		.mode    (MODE),
		.priv_ok (PRIV_OK),
		.iter    (iter_reg),
		.cost    (cost)
	);

	////////////////////////////////////////////////////////////////////////
	// sequential state

	always @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			state_reg    <= ST_OPCODE;
			rep_reg      <= 1'b0;
			op_reg       <= `OP_NONE;
			wide_reg     <= 1'b0;
			word32_reg   <= 1'b0;
			mem_reg      <= 1'b0;
			imm_left_reg <= `IMM_LEN_BYTE;
			imm_idx_reg  <= 2'h0;
			iter_reg     <= 32'h00000000;
			clocks_reg   <= {COST_W{1'b0}};
			valid_reg    <= 1'b0;
			bad_reg      <= 1'b0;
			ready_reg    <= 1'b0;
		end else begin
			state_reg    <= state_next;
			rep_reg      <= rep_next;
			op_reg       <= op_next;
			wide_reg     <= wide_next;
			word32_reg   <= word32_next;
			mem_reg      <= mem_next;
			imm_left_reg <= imm_left_next;
			imm_idx_reg  <= imm_idx_next;
			iter_reg     <= iter_next;
			bad_reg      <= bad_next;
			// stall the queue while a result waits for the sequencer
			ready_reg    <= (state_next != ST_CALC) && (state_next != ST_HOLD);
			if (state_reg == ST_CALC) begin
				clocks_reg <= cost;
				valid_reg  <= 1'b1;
			end else if (state_reg == ST_HOLD && SEQ_ACCEPT) begin
				valid_reg  <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// immediate assembly, little-endian byte lanes

	genvar lane;
	generate
		for (lane = 0; lane < 4; lane = lane + 1) begin : g_imm_lane
			reg [7:0] lane_reg;
			always @(posedge CLK_SYS or negedge RST_B) begin
				if (!RST_B) begin
					lane_reg <= 8'h00;
				end else if (state_reg == ST_OPCODE && take) begin
					// stale upper bytes would corrupt a short immediate
					lane_reg <= 8'h00;
				end else if (state_reg == ST_IMM && take && imm_idx_reg == lane) begin
					lane_reg <= QUEUE_BYTE;
				end
			end
			assign DEC_IMM[8*lane+7:8*lane] = lane_reg;
		end
	endgenerate

	assign QUEUE_READY     = ready_reg;
	assign DEC_VALID       = valid_reg;
	assign DEC_OP          = op_reg;
	assign DEC_WIDE        = wide_reg;
	assign DEC_WORD32      = word32_reg;
	assign DEC_MEM         = mem_reg;
	assign DEC_ITER        = iter_reg;
	assign DEC_CLOCKS      = clocks_reg;
	assign DEC_UNSUPPORTED = bad_reg;

endmodule // logic_string_op_decoder

`default_nettype wire

// ==== hw/decoder_defs.vh ====
// constants shared by the logical/string opcode decoder and its cost calculator
`ifndef DECODER_DEFS_VH
`define DECODER_DEFS_VH

// opcode bytes and 7-bit opcode bodies (size bit stripped)
`define PREFIX_ITERATE  8'hF3
`define ESCAPE_BYTE     8'h0F
`define OPC2_DBL_SHL    8'hA4
`define OPC_GROUP3      7'h7B
`define OPC_TEST_ACC    7'h54
`define OPC_AND_ACC     7'h12
`define OPC_CMP_STR     7'h53
`define OPC_IN_STR      7'h36
`define OPC_OUT_STR     7'h37
`define OPC_LOAD_STR    7'h56
`define OPC_MOVE_STR    7'h52
`define OPC_SCAN_STR    7'h57
`define OPC_STORE_STR   7'h55

// operand-location byte fields
`define MODRM_MOD_MSB   7
`define MODRM_MOD_LSB   6
`define MODRM_REG_MSB   5
`define MODRM_REG_LSB   3
`define MOD_REGISTER    2'h3
`define SUB_TEST        3'h0
`define SUB_INVERT      3'h2

// decoded operation identities
`define OP_NONE         4'h0
`define OP_TEST_IMM     4'h1
`define OP_TEST_ACC     4'h2
`define OP_INVERT       4'h3
`define OP_AND_ACC      4'h4
`define OP_CMP_STR      4'h5
`define OP_IN_STR       4'h6
`define OP_OUT_STR      4'h7
`define OP_LOAD_STR     4'h8
`define OP_MOVE_STR     4'h9
`define OP_SCAN_STR     4'hA
`define OP_STORE_STR    4'hB
`define OP_CMP_REP      4'hC
`define OP_DBL_SHL      4'hD

// operating modes
`define MODE_REAL       2'h0
`define MODE_V86        2'h1
`define MODE_PROT       2'h2

// clock figures
`define CLK_TEST_REG    8'h02
`define CLK_TEST_MEM    8'h05
`define CLK_ACC_IMM     8'h02
`define CLK_INV_REG     8'h02
`define CLK_INV_MEM     8'h06
`define CLK_CMP_STR     8'h0A
`define CLK_IN_REAL     8'h0F
`define CLK_IN_V86      8'h1D
`define CLK_IN_PRIV     8'h09
`define CLK_IN_UNPRIV   8'h1D
`define CLK_OUT_REAL    8'h0E
`define CLK_OUT_V86     8'h1C
`define CLK_OUT_PRIV    8'h08
`define CLK_OUT_UNPRIV  8'h1C
`define CLK_LOAD_STR    8'h05
`define CLK_MOVE_STR    8'h07
`define CLK_SCAN_STR    8'h07
`define CLK_STORE_STR   8'h04
`define CLK_REP_CMP_FIX 8'h05
`define CLK_REP_CMP_PER 4'h9
`define CLK_SHL_REG     8'h03
`define CLK_SHL_MEM     8'h07

// immediate lengths in bytes
`define IMM_LEN_BYTE    3'h1
`define IMM_LEN_WORD    3'h2
`define IMM_LEN_DWORD   3'h4
`define SHORT_COUNT_MSK 32'h0000FFFF

`endif

// ==== hw/clock_cost_calc.v ====
// clock count charged for one decoded operation
`timescale 1ns/1ps
`default_nettype none
`include "decoder_defs.vh"

module clock_cost_calc #(
	parameter COST_W = 40
) (
	input  wire [3:0]        op,
	input  wire              mem,
	input  wire [1:0]        mode,
	input  wire              priv_ok,
	input  wire [31:0]       iter,
	output wire [COST_W-1:0] cost
);

	reg [7:0] fixed;
	reg [3:0] per;

	always @* begin
		fixed = 8'h00;
		per   = 4'h0;
		case (op)
			`OP_TEST_IMM:  fixed = mem ? `CLK_TEST_MEM : `CLK_TEST_REG;
			`OP_TEST_ACC:  fixed = `CLK_ACC_IMM;
			`OP_AND_ACC:   fixed = `CLK_ACC_IMM;
			`OP_INVERT:    fixed = mem ? `CLK_INV_MEM : `CLK_INV_REG;
			`OP_CMP_STR:   fixed = `CLK_CMP_STR;
			`OP_IN_STR: begin
				if (mode == `MODE_REAL)
					fixed = `CLK_IN_REAL;
				else if (mode == `MODE_V86)
					fixed = `CLK_IN_V86;
				else
					fixed = priv_ok ? `CLK_IN_PRIV : `CLK_IN_UNPRIV;
			end
			`OP_OUT_STR: begin
				if (mode == `MODE_REAL)
					fixed = `CLK_OUT_REAL;
				else if (mode == `MODE_V86)
					fixed = `CLK_OUT_V86;
				else
					fixed = priv_ok ? `CLK_OUT_PRIV : `CLK_OUT_UNPRIV;
			end
			`OP_LOAD_STR:  fixed = `CLK_LOAD_STR;
			`OP_MOVE_STR:  fixed = `CLK_MOVE_STR;
			`OP_SCAN_STR:  fixed = `CLK_SCAN_STR;
			`OP_STORE_STR: fixed = `CLK_STORE_STR;
			`OP_CMP_REP: begin
				fixed = `CLK_REP_CMP_FIX;
				per   = `CLK_REP_CMP_PER;
			end
			`OP_DBL_SHL:   fixed = mem ? `CLK_SHL_MEM : `CLK_SHL_REG;
			default: begin
				fixed = 8'h00;
				per   = 4'h0;
			end
		endcase
	end

	assign cost = {{(COST_W-8){1'b0}}, fixed}
		+ ({{(COST_W-4){1'b0}}, per} * {{(COST_W-32){1'b0}}, iter});

endmodule // clock_cost_calc

`default_nettype wire

// ==== tb/decoder_asserts.sv ====
// port assertions for the logic and string decoder
`timescale 1ns/1ps
`default_nettype none

module decoder_asserts #(
	parameter COST_W = 40
) (
	input wire logic              CLK_SYS,
	input wire logic              RST_B,
	input wire logic              QUEUE_READY,
	input wire logic [1:0]        MODE,
	input wire logic              PRIV_OK,
	input wire logic              SEQ_ACCEPT,
	input wire logic              DEC_VALID,
	input wire logic [3:0]        DEC_OP,
	input wire logic              DEC_WIDE,
	input wire logic              DEC_WORD32,
	input wire logic              DEC_MEM,
	input wire logic [31:0]       DEC_IMM,
	input wire logic [31:0]       DEC_ITER,
	input wire logic [COST_W-1:0] DEC_CLOCKS
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	sequence s_new(logic [3:0] op); $rose(DEC_VALID) && DEC_OP == op; endsequence
	sequence s_take; DEC_VALID && SEQ_ACCEPT; endsequence
	sequence s_free; !DEC_VALID && QUEUE_READY; endsequence

	a_test_cost: assert property (s_new(4'h1) |-> DEC_CLOCKS == (DEC_MEM ? 8'h05 : 8'h02))
		else $error("test cost wrong");
	a_acc_cost: assert property ($rose(DEC_VALID) && DEC_OP inside {4'h2, 4'h4} |-> DEC_CLOCKS == 8'h02 && !DEC_MEM)
		else $error("accumulator cost wrong");
	a_invert_cost: assert property (s_new(4'h3) |-> DEC_CLOCKS == (DEC_MEM ? 8'h06 : 8'h02))
		else $error("invert cost wrong");
	a_string_cost: assert property (DEC_VALID && DEC_OP inside {4'h5, 4'h8, 4'h9, 4'hA, 4'hB} |-> DEC_CLOCKS ==
		(DEC_OP == 4'h5 ? 8'h0A : DEC_OP == 4'h8 ? 8'h05 : DEC_OP == 4'hB ? 8'h04 : 8'h07)) else $error("string cost wrong");
	a_in_cost: assert property (s_new(4'h6) |-> DEC_CLOCKS == (MODE == 2'h0 ? 8'h0F : MODE == 2'h1 || !PRIV_OK ? 8'h1D : 8'h09))
		else $error("input cost wrong");
	a_out_cost: assert property (s_new(4'h7) |-> DEC_CLOCKS == (MODE == 2'h0 ? 8'h0E : MODE == 2'h1 || !PRIV_OK ? 8'h1C : 8'h08))
		else $error("output cost wrong");
	a_repeat_cost: assert property (DEC_VALID && DEC_OP == 4'hC |-> DEC_CLOCKS == 8'h05 + 8'h09 * DEC_ITER)
		else $error("repeat cost wrong");
	a_shift_cost: assert property (s_new(4'hD) |-> DEC_CLOCKS == (DEC_MEM ? 8'h07 : 8'h03) && DEC_IMM[31:8] == 24'h0)
		else $error("shift cost wrong");
	a_byte_size: assert property (DEC_VALID && !DEC_WIDE |-> !DEC_WORD32 && DEC_IMM[31:8] == 24'h0)
		else $error("byte operand wrong");
	a_iter_zero: assert property (DEC_VALID && DEC_OP != 4'hC |-> DEC_ITER == 32'h0)
		else $error("iteration count wrong");
	a_accept_free: assert property (s_take |=> s_free)
		else $error("accept release wrong");
	a_result_hold: assert property (DEC_VALID && !SEQ_ACCEPT |=> DEC_VALID && $stable(DEC_CLOCKS))
		else $error("result not held");
endmodule // decoder_asserts

bind logic_string_op_decoder decoder_asserts #(.COST_W(COST_W)) i_chk (
	.CLK_SYS(CLK_SYS), .RST_B(RST_B), .QUEUE_READY(QUEUE_READY), .MODE(MODE), .PRIV_OK(PRIV_OK),
	.SEQ_ACCEPT(SEQ_ACCEPT), .DEC_VALID(DEC_VALID), .DEC_OP(DEC_OP), .DEC_WIDE(DEC_WIDE),
	.DEC_WORD32(DEC_WORD32), .DEC_MEM(DEC_MEM), .DEC_IMM(DEC_IMM), .DEC_ITER(DEC_ITER), .DEC_CLOCKS(DEC_CLOCKS)
);
`default_nettype wire

// ==== tb/queue_seq_model.sv ====
// prefetch queue and sequencer stand-in
`timescale 1ns/1ps
`default_nettype none

module queue_seq_model (
	input  wire logic       CLK_SYS,
	input  wire logic       QUEUE_READY,
	input  wire logic       DEC_VALID,
	input  wire logic [1:0] acc_wait,
	output var  logic       QUEUE_VALID,
	output var  logic [7:0] QUEUE_BYTE,
	output var  logic       SEQ_ACCEPT,
	output var  logic       stuck
);
	int held = 0;

	initial begin
		QUEUE_VALID = 1'b0;
		QUEUE_BYTE = 8'hA5;
		SEQ_ACCEPT = 1'b0;
		stuck = 1'b0;
	end

	// each byte stands until the rising edge that sees ready high
	task automatic send(input logic [63:0] b, input int n);
		int i;
		int t;
		for (i = 0; i < n; i++) begin
			QUEUE_VALID = 1'b1;
			QUEUE_BYTE = b[8*i+:8];
			t = 0;
			// ready is registered: its level at the falling edge is what the next rising edge samples
			while (QUEUE_READY !== 1'b1 && t < 64) begin
				t++;
				@(negedge CLK_SYS);
			end
			if (t >= 64)
				stuck = 1'b1;
			@(negedge CLK_SYS);
		end
		QUEUE_VALID = 1'b0;
		// released line must not look like a valid byte
		QUEUE_BYTE = ~QUEUE_BYTE;
	endtask

	// stall before taking the result, length chosen per transfer
	always @(negedge CLK_SYS) begin
		if (DEC_VALID !== 1'b1) begin
			held = 0;
			SEQ_ACCEPT = 1'b0;
		end else begin
			SEQ_ACCEPT = held >= acc_wait;
			held++;
		end
	end
endmodule // queue_seq_model
`default_nettype wire

// ==== tb/logic_string_op_decoder_tb.sv ====
// self-checking bench for the logic and string decoder
`timescale 1ns/1ps
`default_nettype none

module logic_string_op_decoder_tb;
	localparam int CW = 40;
	logic          CLK_SYS = 1'b0;
	logic          RST_B = 1'b0;
	logic [1:0]    MODE = 2'h0;
	logic          PRIV_OK = 1'b0;
	logic          OPERAND_32 = 1'b0;
	logic          COUNT_WIDE = 1'b0;
	logic [31:0]   COUNT_VALUE = 32'h0;
	logic [1:0]    acc_wait = 2'h0;
	logic [31:0]   r;
	wire           QUEUE_VALID, QUEUE_READY, SEQ_ACCEPT, stuck;
	wire           DEC_VALID, DEC_WIDE, DEC_WORD32, DEC_MEM, DEC_UNSUPPORTED;
	wire [7:0]     QUEUE_BYTE;
	wire [3:0]     DEC_OP;
	wire [31:0]    DEC_IMM, DEC_ITER;
	wire [CW-1:0]  DEC_CLOCKS;
	logic [6:0]    str_opc [5:11] = '{7'h53, 7'h36, 7'h37, 7'h56, 7'h52, 7'h57, 7'h55};
	logic [15:0]   bad [4] = '{16'hA4F3, 16'hA50F, 16'hC8F6, 16'h0FF3};
	int            err_count = 0, n_tests = 0, seed = 74, unsup = 0, k;

	always #5 CLK_SYS = ~CLK_SYS;
	always @(negedge CLK_SYS) if (DEC_UNSUPPORTED === 1'b1) unsup++;

	logic_string_op_decoder #(.COST_W(CW)) i_dut (
		.CLK_SYS(CLK_SYS), .RST_B(RST_B), .QUEUE_VALID(QUEUE_VALID), .QUEUE_BYTE(QUEUE_BYTE),
		.QUEUE_READY(QUEUE_READY), .MODE(MODE), .PRIV_OK(PRIV_OK), .OPERAND_32(OPERAND_32),
		.COUNT_WIDE(COUNT_WIDE), .COUNT_VALUE(COUNT_VALUE), .SEQ_ACCEPT(SEQ_ACCEPT), .DEC_VALID(DEC_VALID),
		.DEC_OP(DEC_OP), .DEC_WIDE(DEC_WIDE), .DEC_WORD32(DEC_WORD32), .DEC_MEM(DEC_MEM), .DEC_IMM(DEC_IMM),
		.DEC_ITER(DEC_ITER), .DEC_CLOCKS(DEC_CLOCKS), .DEC_UNSUPPORTED(DEC_UNSUPPORTED));
	queue_seq_model i_model (.CLK_SYS(CLK_SYS), .QUEUE_READY(QUEUE_READY), .DEC_VALID(DEC_VALID),
		.acc_wait(acc_wait), .QUEUE_VALID(QUEUE_VALID), .QUEUE_BYTE(QUEUE_BYTE), .SEQ_ACCEPT(SEQ_ACCEPT), .stuck(stuck));

	function automatic logic [CW-1:0] cost(input logic [3:0] op, input logic mem, input logic [31:0] n);
		case (op)
		4'h1: cost = mem ? 8'h05 : 8'h02;
		4'h3: cost = mem ? 8'h06 : 8'h02;
		4'h5: cost = 8'h0A;
		4'h6: cost = MODE == 2'h0 ? 8'h0F : MODE == 2'h1 || !PRIV_OK ? 8'h1D : 8'h09;
		4'h7: cost = MODE == 2'h0 ? 8'h0E : MODE == 2'h1 || !PRIV_OK ? 8'h1C : 8'h08;
		4'h8: cost = 8'h05;
		4'h9, 4'hA: cost = 8'h07;
		4'hB: cost = 8'h04;
		4'hC: cost = 8'h05 + 8'h09 * n;
		4'hD: cost = mem ? 8'h07 : 8'h03;
		default: cost = 8'h02;
		endcase
	endfunction

	task automatic chk(input string what, input logic [CW-1:0] exp, input logic [CW-1:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask

	task automatic conclude();
		if (err_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wait_valid(input logic want);
		int t;
		t = 0;
		while (DEC_VALID !== want && t < 64) begin
			t++;
			@(negedge CLK_SYS);
		end
		if (t >= 64) begin
			err_count++;
			conclude();
		end
	endtask

	task automatic run(input logic [3:0] op);
		logic [63:0] b;
		logic [31:0] imm, n, q;
		logic [7:0] mrm;
		logic w, mem;
		int il, len;
		q = $random(seed);
		imm = $random(seed);
		w = q[8];
		mrm = q[7:0];
		mem = op inside {4'h1, 4'h3, 4'hD} && mrm[7:6] != 2'h3;
		il = op inside {4'h1, 4'h2, 4'h4} ? (!w ? 1 : OPERAND_32 ? 4 : 2) : op == 4'hD ? 1 : 0;
		imm = il == 4 ? imm : imm & ((32'h1 << (8 * il)) - 32'h1);
		n = op != 4'hC ? 32'h0 : COUNT_WIDE ? COUNT_VALUE : COUNT_VALUE & 32'h0000FFFF;
		len = 1 + il;
		case (op)
		4'h1, 4'h3: begin
			mrm[5:3] = {1'b0, op == 4'h3, 1'b0};
			b = {imm, mrm, 7'h7B, w};
			len = 2 + il;
		end
		4'h2: b = {imm, 7'h54, w};
		4'h4: b = {imm, 7'h12, w};
		4'hC: b = {7'h53, w, 8'hF3};
		4'hD: b = {imm[7:0], mrm, 16'hA40F};
		default: b = {str_opc[op], w};
		endcase
		if (op inside {4'hC, 4'hD})
			len = op == 4'hC ? 2 : 4;
		acc_wait = q[10:9];
		i_model.send(b, len);
		wait_valid(1'b1);
		chk("op", op, DEC_OP);
		chk("mem", mem, DEC_MEM);
		chk("imm", imm, DEC_IMM);
		chk("iter", n, DEC_ITER);
		chk("clocks", cost(op, mem, n), DEC_CLOCKS);
		if (op != 4'hD)
			chk("size", {w, w & OPERAND_32}, {DEC_WIDE, DEC_WORD32});
		wait_valid(1'b0);
	endtask

	initial begin
		repeat (2) @(negedge CLK_SYS);
		chk("reset ready", 0, QUEUE_READY);
		RST_B = 1'b1;
		// refused sequences: wrong follower, wrong escape, bad sub-field
		for (k = 0; k < 4; k++) begin
			i_model.send({48'h0, bad[k]}, 2);
			repeat (3) @(negedge CLK_SYS);
			chk("unsupported", k + 1, unsup);
			chk("no result", 0, DEC_VALID);
		end
		for (k = 0; k < 130; k++) begin
			r = $random(seed);
			MODE = 2'(k / 13);
			{PRIV_OK, OPERAND_32} = r[1:0];
			COUNT_WIDE = k > 25 && r[2];
			COUNT_VALUE = k < 13 ? 32'h00010003 : k < 26 ? 32'h0 : $random(seed);
			run(4'(k % 13 + 1));
		end
		chk("stall", 0, stuck);
		conclude();
	end
endmodule // logic_string_op_decoder_tb
`default_nettype wire
